// file: verif/crs_stack_mem.sv
// crs_stack_mem: behavioural 4-bit stack data memory
`timescale 1ns/1ns
module crs_stack_mem (
  input wire logic clk, en, we, re,
  input wire logic [7:0] addr,
  input wire logic [3:0] wdata,
  output logic [3:0] rdata = 4'h0
);
  logic [3:0] mem [256]; // stack words, preloadable
  // read data stand one cycle, then the line shows junk
  always @(posedge clk) begin
    if (en && we) mem[addr] <= wdata;
    if (en) rdata <= re ? mem[addr] : ~rdata;
  end
endmodule

// file: verif/crs_unit_assertions.sv
// crs_unit_assertions: timing checks on the unit's command and stack ports
`timescale 1ns/1ns
module crs_unit_assertions (
  input wire logic ref_clk, rst_n, clkEn, cmdValid, cmdReady,
  input wire crs_pkg::crs_op_type cmdOp,
  input wire logic sixWordMode, memWe, memRe, pcLoad, skipNext, popLoad,
  input wire logic [7:0] memAddr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic acc; // command taken this edge
  assign acc = cmdValid && cmdReady && clkEn;
  sequence wr4;
    memWe [*4];
  endsequence
  sequence wr5;
    memWe [*5];
  endsequence
  mem_exclusive_a: assert property (!(memWe && memRe))
    else $error("write and read together");
  push_descend_a: assert property (memWe && $past(memWe) |->
    memAddr == $past(memAddr) - 8'h01) else $error("push order");
  pop_ascend_a: assert property (memRe && $past(memRe) |->
    memAddr == $past(memAddr) + 8'h01) else $error("pop order");
  skip_pulse_a: assert property (skipNext |-> pcLoad)
    else $error("lone skip");
  branch_load_a: assert property (acc && (cmdOp == crs_pkg::OP_BR_BCDE ||
    cmdOp == crs_pkg::OP_BR_BCXA) |-> ##2 pcLoad && !memWe)
    else $error("branch timing");
  call_four_a: assert property (acc && cmdOp == crs_pkg::OP_CALL &&
    !sixWordMode |=> ##1 wr4 ##1 pcLoad && !memWe) else $error("call4");
  call_six_a: assert property (acc && (cmdOp == crs_pkg::OP_CALL ||
    cmdOp == crs_pkg::OP_SHORT_CALL) && sixWordMode |=> ##1 wr5 ##1
    pcLoad && !memWe) else $error("call6");
  pop_pair_a: assert property (acc && cmdOp == crs_pkg::OP_POP_PAIR
    |=> ##1 memRe [*2] ##[2:3] popLoad) else $error("pop timing");
  interrupt_return_read_a: assert property (acc && cmdOp == crs_pkg::OP_INTERRUPT_RETURN
    |=> ##1 memRe [*6] ##[2:3] pcLoad) else $error("interrupt_return timing");
endmodule
bind crs_unit crs_unit_assertions i_chk (.ref_clk, .rst_n, .clkEn,
  .cmdValid, .cmdReady, .cmdOp, .sixWordMode, .memWe, .memRe, .pcLoad,
  .skipNext, .popLoad, .memAddr);

// file: verif/crs_unit_test.sv
// crs_unit_test: directed bench of the call/return stack unit
`timescale 1ns/1ns
module crs_unit_test;
  logic ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, regWr = 1'b0;
  logic regRd = 1'b0, cmdValid = 1'b0, sixWordMode = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00, regRdata, memAddr;
  crs_pkg::crs_op_type cmdOp = crs_pkg::OP_CALL;
  logic [12:0] cmdTarget = 13'h1234, retPc = 13'h1ABC, pcOut;
  logic [3:0] regA = 4'h6, regX = 4'h5, regB = 4'h1, regC = 4'h2;
  logic [3:0] regD = 4'h3, regE = 4'h7, pairHi = 4'h5, pairLo = 4'h6;
  logic [3:0] memWdata, memRdata, popHi, popLo;
  logic cmdReady, memWe, memRe, pcLoad, skipNext, popLoad, busy;
  int miscompares = 0, checks = 0;
  crs_unit i_dut (.*);
  crs_stack_mem i_mem (.clk(ref_clk), .en(clkEn), .we(memWe), .re(memRe),
    .addr(memAddr), .wdata(memWdata), .rdata(memRdata));
  always #5 ref_clk = ~ref_clk;
  task automatic end_sim;
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic cmd(input crs_pkg::crs_op_type o, input logic s);
    int n = 0;
    @(posedge ref_clk);
    cmdOp <= o;
    {sixWordMode, cmdValid} <= {s, 1'b1};
    @(posedge ref_clk);
    // format flips once the command is taken
    {cmdValid, sixWordMode} <= {1'b0, ~s};
    #1 chk(busy, 1'b1);
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (!cmdReady && n < 20);
    chk({busy, cmdReady}, 16'h1);
  endtask
  task automatic mchk(input logic [7:0] a, input logic [23:0] w, input int n);
    for (int i = 0; i < n; i++) chk(i_mem.mem[a - i], w[4*i +: 4]);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(2'h0, 8'h40);
    wr(2'h1, 8'h03);
    wr(2'h2, 8'h0A);
    wr(2'h3, 8'h02);
    cmd(crs_pkg::OP_CALL, 1'b0);
    chk(pcOut, 16'h1234);
    mchk(8'h3F, 24'hADCB, 4);
    rd(2'h0, 8'h3C);
    wr(2'h1, 8'hF0);
    cmd(crs_pkg::OP_RET, 1'b0);
    chk(pcOut, 16'h1ABC);
    rd(2'h0, 8'h40);
    rd(2'h1, 8'hF3);
    @(posedge ref_clk) cmdTarget <= 13'h1FFF;
    cmd(crs_pkg::OP_SHORT_CALL, 1'b1);
    chk(pcOut, 16'h07FF);
    mchk(8'h3E, 24'hA1CB3, 5);
    rd(2'h0, 8'h3A);
    wr(2'h1, 8'h00);
    cmd(crs_pkg::OP_RETURN_AND_SKIP, 1'b1);
    chk({pcLoad, skipNext, pcOut}, 16'h7ABC);
    rd(2'h1, 8'h03);
    cmd(crs_pkg::OP_CALL, 1'b0);
    cmd(crs_pkg::OP_RETURN_AND_SKIP, 1'b0);
    rd(2'h1, 8'h02);
    cmd(crs_pkg::OP_PUSH_PAIR, 1'b0);
    mchk(8'h3F, 24'h65, 2);
    cmd(crs_pkg::OP_POP_PAIR, 1'b0);
    chk({popLoad, popHi, popLo}, 16'h156);
    cmd(crs_pkg::OP_PUSH_BS, 1'b0);
    mchk(8'h3F, 24'h2A, 2);
    wr(2'h2, 8'h00);
    wr(2'h3, 8'h00);
    cmd(crs_pkg::OP_POP_BS, 1'b0);
    rd(2'h2, 8'h0A);
    rd(2'h3, 8'h02);
    for (int i = 0; i < 6; i++) i_mem.mem[8'h40 + i] = 4'(24'h973412 >> 4*i);
    cmd(crs_pkg::OP_INTERRUPT_RETURN, 1'b0);
    chk(pcOut, 16'h1234);
    rd(2'h1, 8'h97);
    rd(2'h0, 8'h46);
    cmd(crs_pkg::OP_BR_BCDE, 1'b0);
    chk({pcLoad, pcOut}, 16'h3237);
    cmd(crs_pkg::OP_BR_BCXA, 1'b0);
    chk({pcLoad, pcOut}, 16'h3256);
    end_sim;
  end
  // watchdog: a hang counts as one mismatch
  initial begin
    #20000;
    chk(16'h0000, 16'h0001);
    end_sim;
  end
endmodule

// file: verilog/crs_frame_word.sv
// crs_frame_word: offset and data of one pushed stack word
`timescale 1ns/1ns
module crs_frame_word (
  input wire crs_pkg::crs_op_type op,
  input wire logic six,
  input wire logic [2:0] step,
  input wire logic [12:0] pc,
  input wire logic mem_bank_enable_flag,
  input wire logic reg_bank_enable_flag,
  input wire logic [3:0] hi,
  input wire logic [3:0] lo,
  input wire logic [3:0] mem_bank_select,
  input wire logic [1:0] reg_bank_select,
  output logic [2:0] off,
  output logic [3:0] word
);
  logic [3:0] pcLo;  // return address nibbles
  logic [3:0] pcMid;
  logic [3:0] pcHi;
  assign pcLo = pc[crs_pkg::PC_LO_LSB +: crs_pkg::NIB_W];
  assign pcMid = pc[crs_pkg::PC_MID_LSB +: crs_pkg::NIB_W];
  assign pcHi = pc[crs_pkg::PC_HI_LSB +: crs_pkg::NIB_W];
  // word written at step, address below the stack pointer
  always_comb begin
    word = 4'h0;
    off = step + crs_pkg::SKEW1;
    unique case (op)
      crs_pkg::OP_CALL, crs_pkg::OP_SHORT_CALL: begin
        if (six) begin
          off = step + crs_pkg::SKEW6;
          unique case (step)
            3'h0: word = {2'b00, mem_bank_enable_flag, reg_bank_enable_flag};
            3'h1: word = pcMid;
            3'h2: word = pcLo;
            3'h3: word = {3'b000, pc[crs_pkg::PC_TOP]};
            default: word = pcHi;
          endcase
        end else begin
          unique case (step)
            3'h0: word = pcMid;
            3'h1: word = pcLo;
            3'h2: word = {mem_bank_enable_flag, reg_bank_enable_flag, 1'b0, pc[crs_pkg::PC_TOP]};
            default: word = pcHi;
          endcase
        end
      end
      // high at SP-1, low at SP-2
      crs_pkg::OP_PUSH_PAIR: word = (step == 3'h0) ? hi : lo;
      // memory select first, register select second
      crs_pkg::OP_PUSH_BS: word = (step == 3'h0) ? mem_bank_select : {2'b00, reg_bank_select};
      default: word = 4'h0;
    endcase
  end
endmodule

// file: verilog/crs_pkg.sv
// crs_pkg: shared constants and types of the call/return stack unit
package crs_pkg;
  // ***************************************************
  // widths
  // ***************************************************
  localparam int PC_W = 13;       // program counter width
  localparam int SP_W = 8;        // stack pointer width
  localparam int NIB_W = 4;       // one data memory word
  localparam int SW_W = 8;        // status word width
  localparam int RBS_W = 2;       // register bank select width
  localparam int REG_AW = 2;      // register port address width
  localparam int SHORT_W = 11;    // short call immediate width
  localparam int STEP_W = 3;      // frame step counter width
  localparam int BUF_N = 6;       // words of the largest read frame
  // ***************************************************
  // program counter nibble positions
  // ***************************************************
  localparam int PC_LO_LSB = 0;   // bits 3-0
  localparam int PC_MID_LSB = 4;  // bits 7-4
  localparam int PC_HI_LSB = 8;   // bits 11-8
  localparam int PC_TOP = 12;     // bit 12
  // ***************************************************
  // frame word fields
  // ***************************************************
  localparam int FLG_MBE = 3;     // four-word flag word: bank enables
  localparam int FLG_RBE = 2;
  localparam int FLG_PC12 = 0;    // flag word: program counter bit 12
  localparam int EXT_MBE = 1;     // six-word extra word: bank enables
  localparam int EXT_RBE = 0;
  localparam int ST_MBE = 1;      // status word bit positions
  localparam int ST_RBE = 0;
  // read frame word index, counted up from the stack pointer
  localparam int RD_PCH = 0;
  localparam int RD_FLG = 1;
  localparam int RD_PCL = 2;
  localparam int RD_PCM = 3;
  localparam int RD_EXT = 4;
  localparam int RD_SWH = 5;
  // ***************************************************
  // frame sizes and pointer moves
  // ***************************************************
  localparam logic [2:0] CALL6_WORDS = 3'h5;
  localparam logic [2:0] CALL4_WORDS = 3'h4;
  localparam logic [2:0] RET6_WORDS = 3'h5;
  localparam logic [2:0] RET4_WORDS = 3'h4;
  localparam logic [2:0] INTERRUPT_RETURN_WORDS = 3'h6;
  localparam logic [2:0] PAIR_WORDS = 3'h2;
  localparam logic [2:0] DELTA6 = 3'h6;
  localparam logic [2:0] DELTA4 = 3'h4;
  localparam logic [2:0] DELTA2 = 3'h2;
  localparam logic [2:0] DELTA0 = 3'h0;
  localparam logic [2:0] SKEW6 = 3'h2;  // six-word call starts at SP-2
  localparam logic [2:0] SKEW1 = 3'h1;  // other pushes start at SP-1
  // ***************************************************
  // register port map and reset values
  // ***************************************************
  localparam logic [1:0] REG_SP = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_MBS = 2'h2;
  localparam logic [1:0] REG_RBS = 2'h3;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [7:0] SW_RST = 8'h00;
  localparam logic [3:0] MBS_RST = 4'h0;
  localparam logic [1:0] RBS_RST = 2'h0;
  // ***************************************************
  // commands and sequencer states
  // ***************************************************
  typedef enum logic [3:0] {
    OP_BR_BCDE, OP_BR_BCXA, OP_CALL, OP_SHORT_CALL, OP_RET, OP_RETURN_AND_SKIP,
    OP_INTERRUPT_RETURN, OP_PUSH_PAIR, OP_PUSH_BS, OP_POP_PAIR, OP_POP_BS
  } crs_op_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WRITE, ST_READ, ST_DRAIN, ST_LAST, ST_FINISH
  } crs_state_type;
endpackage

// file: verilog/crs_stack_addr.sv
// crs_stack_addr: stack pointer plus or minus a small offset
`timescale 1ns/1ns
module crs_stack_addr (
  input wire logic [7:0] base,
  input wire logic [2:0] off,
  input wire logic down,
  output logic [7:0] result
);
  // wraps inside the 256-word stack space
  always_comb begin
    if (down) begin
      result = base - {5'h00, off};
    end else begin
      result = base + {5'h00, off};
    end
  end
endmodule

// file: verilog/crs_unit.sv
// crs_unit: call, return, push and pop execution over the stack memory
`timescale 1ns/1ns
module crs_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic sixWordMode,
  input wire logic cmdValid,
  input wire crs_pkg::crs_op_type cmdOp,
  output logic cmdReady,
  input wire logic [12:0] cmdTarget,
  input wire logic [12:0] retPc,
  input wire logic [3:0] regA,
  input wire logic [3:0] regX,
  input wire logic [3:0] regB,
  input wire logic [3:0] regC,
  input wire logic [3:0] regD,
  input wire logic [3:0] regE,
  input wire logic [3:0] pairHi,
  input wire logic [3:0] pairLo,
  output logic [7:0] memAddr,
  output logic [3:0] memWdata,
  output logic memWe,
  output logic memRe,
  input wire logic [3:0] memRdata,
  output logic [12:0] pcOut,
  output logic pcLoad,
  output logic skipNext,
  output logic [3:0] popHi,
  output logic [3:0] popLo,
  output logic popLoad,
  output logic busy
);
  // ***************************************************
  // declarations
  // ***************************************************
  crs_pkg::crs_state_type stateFf, nxt_stateFf;  // sequencer state
  crs_pkg::crs_op_type opFf, nxt_opFf;           // command held
  logic sixFf, nxt_sixFf;                        // frame format held
  logic [2:0] stepFf, nxt_stepFf;                // frame word index
  logic [2:0] countFf, nxt_countFf;              // words in frame
  logic [2:0] deltaFf, nxt_deltaFf;              // stack pointer move
  logic downFf, nxt_downFf;                      // move direction
  logic [12:0] retPcFf, nxt_retPcFf;             // return address
  logic [12:0] targetFf, nxt_targetFf;           // branch target
  logic [3:0] hiFf, nxt_hiFf;                    // pushed pair
  logic [3:0] loFf, nxt_loFf;
  logic [7:0] spFf, nxt_spFf;                    // stack pointer
  logic [7:0] swFf, nxt_swFf;                    // status word
  logic [3:0] mbsFf, nxt_mbsFf;                  // memory bank select
  logic [1:0] rbsFf, nxt_rbsFf;                  // register bank select
  logic [7:0] rdataFf, nxt_rdataFf;              // register read data
  logic [7:0] memAddrFf, nxt_memAddrFf;          // memory port
  logic [3:0] memWdataFf, nxt_memWdataFf;
  logic memWeFf, nxt_memWeFf;
  logic memReFf, nxt_memReFf;
  logic rdValidFf, nxt_rdValidFf;                // read data stands now
  logic [2:0] capIdxFf, nxt_capIdxFf;            // next buffer slot
  logic [12:0] pcOutFf, nxt_pcOutFf;             // result outputs
  logic pcLoadFf, nxt_pcLoadFf;
  logic skipFf, nxt_skipFf;
  logic [3:0] popHiFf, nxt_popHiFf;
  logic [3:0] popLoFf, nxt_popLoFf;
  logic popLoadFf, nxt_popLoadFf;
  logic [3:0] bufFf [crs_pkg::BUF_N];            // read frame words
  logic [2:0] wrOff;                             // push word offset
  logic [3:0] wrWord;                            // push word data
  logic [7:0] wrAddr;                            // push word address
  logic [7:0] rdAddr;                            // pop word address
  logic [7:0] spMoved;                           // pointer after frame
  logic [12:0] retTarget;                        // return address read
  // ***************************************************
  // datapath helpers
  // ***************************************************
  crs_frame_word u_word (
    .op(opFf),
    .six(sixFf),
    .step(stepFf),
    .pc(retPcFf),
    .mem_bank_enable_flag(swFf[crs_pkg::ST_MBE]),
    .reg_bank_enable_flag(swFf[crs_pkg::ST_RBE]),
    .hi(hiFf),
    .lo(loFf),
    .mem_bank_select(mbsFf),
    .reg_bank_select(rbsFf),
    .off(wrOff),
    .word(wrWord)
  );
  crs_stack_addr u_wr_addr (
    .base(spFf),
    .off(wrOff),
    .down(1'b1),
    .result(wrAddr)
  );
  crs_stack_addr u_rd_addr (
    .base(spFf),
    .off(stepFf),
    .down(1'b0),
    .result(rdAddr)
  );
  crs_stack_addr u_sp_move (
    .base(spFf),
    .off(deltaFf),
    .down(downFf),
    .result(spMoved)
  );
  // return address: 11-8 at SP, 12 at SP+1, 3-0, then 7-4
  assign retTarget = {bufFf[crs_pkg::RD_FLG][crs_pkg::FLG_PC12],
                      bufFf[crs_pkg::RD_PCH], bufFf[crs_pkg::RD_PCM],
                      bufFf[crs_pkg::RD_PCL]};
  // ***************************************************
  // read capture buffer
  // ***************************************************
  genvar gi;
  generate
    for (gi = 0; gi < crs_pkg::BUF_N; gi++) begin : g_buf
      logic [3:0] nxt_buf;  // next value of this entry
      always_comb begin
        nxt_buf = bufFf[gi];
        if (rdValidFf && (capIdxFf == 3'(gi))) begin
          nxt_buf = memRdata;
        end
      end
      // entry register, frozen with the clock enable
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          bufFf[gi] <= 4'h0;
        end else if (clkEn) begin
          bufFf[gi] <= nxt_buf;
        end
      end
    end
  endgenerate
  // ***************************************************
  // sequencer, memory port and results
  // ***************************************************
  // next state of the instruction sequence
  always_comb begin
    nxt_stateFf = stateFf;
    nxt_opFf = opFf;
    nxt_sixFf = sixFf;
    nxt_stepFf = stepFf;
    nxt_countFf = countFf;
    nxt_deltaFf = deltaFf;
    nxt_downFf = downFf;
    nxt_retPcFf = retPcFf;
    nxt_targetFf = targetFf;
    nxt_hiFf = hiFf;
    nxt_loFf = loFf;
    nxt_memAddrFf = 8'h00;
    nxt_memWdataFf = 4'h0;
    nxt_memWeFf = 1'b0;
    nxt_memReFf = 1'b0;
    nxt_rdValidFf = memReFf;
    nxt_capIdxFf = rdValidFf ? capIdxFf + 3'h1 : capIdxFf;
    nxt_pcOutFf = pcOutFf;
    nxt_pcLoadFf = 1'b0;
    nxt_skipFf = 1'b0;
    nxt_popHiFf = popHiFf;
    nxt_popLoFf = popLoFf;
    nxt_popLoadFf = 1'b0;
    unique case (stateFf)
      crs_pkg::ST_IDLE: begin
        if (cmdValid) begin
          nxt_opFf = cmdOp;
          nxt_sixFf = sixWordMode;
          nxt_stepFf = 3'h0;
          nxt_capIdxFf = 3'h0;
          nxt_retPcFf = retPc;
          nxt_hiFf = pairHi;
          nxt_loFf = pairLo;
          nxt_targetFf = cmdTarget;
          nxt_deltaFf = crs_pkg::DELTA2;
          nxt_countFf = crs_pkg::PAIR_WORDS;
          nxt_downFf = 1'b0;
          nxt_stateFf = crs_pkg::ST_READ;
          unique case (cmdOp)
            crs_pkg::OP_BR_BCDE: begin
              // B bit 0 with C, D, E
              nxt_targetFf = {regB[0], regC, regD, regE};
              nxt_deltaFf = crs_pkg::DELTA0;
              nxt_stateFf = crs_pkg::ST_FINISH;
            end
            crs_pkg::OP_BR_BCXA: begin
              // B bit 0 with C, X, A
              nxt_targetFf = {regB[0], regC, regX, regA};
              nxt_deltaFf = crs_pkg::DELTA0;
              nxt_stateFf = crs_pkg::ST_FINISH;
            end
            crs_pkg::OP_CALL, crs_pkg::OP_SHORT_CALL: begin
              nxt_downFf = 1'b1;
              nxt_stateFf = crs_pkg::ST_WRITE;
              nxt_countFf = sixWordMode ? crs_pkg::CALL6_WORDS
                                        : crs_pkg::CALL4_WORDS;
              nxt_deltaFf = sixWordMode ? crs_pkg::DELTA6
                                        : crs_pkg::DELTA4;
              if (cmdOp == crs_pkg::OP_SHORT_CALL) begin
                nxt_targetFf = {{(crs_pkg::PC_W - crs_pkg::SHORT_W){1'b0}},
                                cmdTarget[crs_pkg::SHORT_W-1:0]};
              end
            end
            crs_pkg::OP_RET, crs_pkg::OP_RETURN_AND_SKIP: begin
              nxt_countFf = sixWordMode ? crs_pkg::RET6_WORDS
                                        : crs_pkg::RET4_WORDS;
              nxt_deltaFf = sixWordMode ? crs_pkg::DELTA6
                                        : crs_pkg::DELTA4;
            end
            crs_pkg::OP_INTERRUPT_RETURN: begin
              nxt_countFf = crs_pkg::INTERRUPT_RETURN_WORDS;
              nxt_deltaFf = crs_pkg::DELTA6;
            end
            crs_pkg::OP_PUSH_PAIR, crs_pkg::OP_PUSH_BS: begin
              nxt_downFf = 1'b1;
              nxt_stateFf = crs_pkg::ST_WRITE;
            end
            default: begin
              // pair and bank pops keep the two-word read
              nxt_stateFf = crs_pkg::ST_READ;
            end
          endcase
        end
      end
      crs_pkg::ST_WRITE: begin
        // one word per cycle, in frame order
        nxt_memAddrFf = wrAddr;
        nxt_memWdataFf = wrWord;
        nxt_memWeFf = 1'b1;
        nxt_stepFf = stepFf + 3'h1;
        if (stepFf == countFf - 3'h1) begin
          nxt_stateFf = crs_pkg::ST_FINISH;
        end
      end
      crs_pkg::ST_READ: begin
        // reads issued back to back from SP upward
        nxt_memAddrFf = rdAddr;
        nxt_memReFf = 1'b1;
        nxt_stepFf = stepFf + 3'h1;
        if (stepFf == countFf - 3'h1) begin
          nxt_stateFf = crs_pkg::ST_DRAIN;
        end
      end
      // last read strobe stands on the port
      crs_pkg::ST_DRAIN: nxt_stateFf = crs_pkg::ST_LAST;
      // last read word is captured
      crs_pkg::ST_LAST: nxt_stateFf = crs_pkg::ST_FINISH;
      crs_pkg::ST_FINISH: begin
        nxt_stateFf = crs_pkg::ST_IDLE;
        unique case (opFf)
          crs_pkg::OP_BR_BCDE, crs_pkg::OP_BR_BCXA,
          crs_pkg::OP_CALL, crs_pkg::OP_SHORT_CALL: begin
            // jump to the target, for calls after the frame is written
            nxt_pcOutFf = targetFf;
            nxt_pcLoadFf = 1'b1;
          end
          crs_pkg::OP_RET, crs_pkg::OP_INTERRUPT_RETURN: begin
            nxt_pcOutFf = retTarget;
            nxt_pcLoadFf = 1'b1;
          end
          crs_pkg::OP_RETURN_AND_SKIP: begin
            // unconditional skip at the return address
            nxt_pcOutFf = retTarget;
            nxt_pcLoadFf = 1'b1;
            nxt_skipFf = 1'b1;
          end
          crs_pkg::OP_POP_PAIR: begin
            // low from SP, high from SP+1
            nxt_popLoFf = bufFf[0];
            nxt_popHiFf = bufFf[1];
            nxt_popLoadFf = 1'b1;
          end
          default: begin
            // pushes and bank pop end without a result pulse
          end
        endcase
      end
      default: nxt_stateFf = crs_pkg::ST_IDLE;
    endcase
  end
  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stateFf <= crs_pkg::ST_IDLE;
      opFf <= crs_pkg::OP_BR_BCDE;
      sixFf <= 1'b0;
      stepFf <= 3'h0;
      countFf <= 3'h0;
      deltaFf <= 3'h0;
      downFf <= 1'b0;
      retPcFf <= 13'h0000;
      targetFf <= 13'h0000;
      hiFf <= 4'h0;
      loFf <= 4'h0;
      memAddrFf <= 8'h00;
      memWdataFf <= 4'h0;
      memWeFf <= 1'b0;
      memReFf <= 1'b0;
      rdValidFf <= 1'b0;
      capIdxFf <= 3'h0;
      pcOutFf <= 13'h0000;
      pcLoadFf <= 1'b0;
      skipFf <= 1'b0;
      popHiFf <= 4'h0;
      popLoFf <= 4'h0;
      popLoadFf <= 1'b0;
    end else if (clkEn) begin
      stateFf <= nxt_stateFf;
      opFf <= nxt_opFf;
      sixFf <= nxt_sixFf;
      stepFf <= nxt_stepFf;
      countFf <= nxt_countFf;
      deltaFf <= nxt_deltaFf;
      downFf <= nxt_downFf;
      retPcFf <= nxt_retPcFf;
      targetFf <= nxt_targetFf;
      hiFf <= nxt_hiFf;
      loFf <= nxt_loFf;
      memAddrFf <= nxt_memAddrFf;
      memWdataFf <= nxt_memWdataFf;
      memWeFf <= nxt_memWeFf;
      memReFf <= nxt_memReFf;
      rdValidFf <= nxt_rdValidFf;
      capIdxFf <= nxt_capIdxFf;
      pcOutFf <= nxt_pcOutFf;
      pcLoadFf <= nxt_pcLoadFf;
      skipFf <= nxt_skipFf;
      popHiFf <= nxt_popHiFf;
      popLoFf <= nxt_popLoFf;
      popLoadFf <= nxt_popLoadFf;
    end
  end
  // ***************************************************
  // architectural registers and register port
  // ***************************************************
  // software writes first, the finishing instruction overrides
  always_comb begin
    nxt_spFf = spFf;
    nxt_swFf = swFf;
    nxt_mbsFf = mbsFf;
    nxt_rbsFf = rbsFf;
    nxt_rdataFf = 8'h00;
    if (regWr) begin
      unique case (regAddr)
        crs_pkg::REG_SP: nxt_spFf = regWdata;
        crs_pkg::REG_STATUS: nxt_swFf = regWdata;
        crs_pkg::REG_MBS: nxt_mbsFf = regWdata[crs_pkg::NIB_W-1:0];
        default: nxt_rbsFf = regWdata[crs_pkg::RBS_W-1:0];
      endcase
    end
    if (regRd) begin
      unique case (regAddr)
        crs_pkg::REG_SP: nxt_rdataFf = spFf;
        crs_pkg::REG_STATUS: nxt_rdataFf = swFf;
        crs_pkg::REG_MBS: nxt_rdataFf = {4'h0, mbsFf};
        default: nxt_rdataFf = {6'h00, rbsFf};
      endcase
    end
    if (stateFf == crs_pkg::ST_FINISH) begin
      // pointer moves by deltaFf: 6, 4 or 2 words, none for branches
      nxt_spFf = spMoved;
      unique case (opFf)
        crs_pkg::OP_RET, crs_pkg::OP_RETURN_AND_SKIP: begin
          // only the two bank enables change
          if (sixFf) begin
            nxt_swFf[crs_pkg::ST_MBE] =
              bufFf[crs_pkg::RD_EXT][crs_pkg::EXT_MBE];
            nxt_swFf[crs_pkg::ST_RBE] =
              bufFf[crs_pkg::RD_EXT][crs_pkg::EXT_RBE];
          end else begin
            nxt_swFf[crs_pkg::ST_MBE] =
              bufFf[crs_pkg::RD_FLG][crs_pkg::FLG_MBE];
            // skipping return clears the register enable
            nxt_swFf[crs_pkg::ST_RBE] = (opFf == crs_pkg::OP_RET) &
              bufFf[crs_pkg::RD_FLG][crs_pkg::FLG_RBE];
          end
        end
        // low nibble from SP+4, high from SP+5
        crs_pkg::OP_INTERRUPT_RETURN: nxt_swFf = {bufFf[crs_pkg::RD_SWH],
                                      bufFf[crs_pkg::RD_EXT]};
        crs_pkg::OP_POP_BS: begin
          // register select at SP, memory select at SP+1
          nxt_rbsFf = bufFf[0][crs_pkg::RBS_W-1:0];
          nxt_mbsFf = bufFf[1];
        end
        default: begin
          // other commands leave the status and selects alone
        end
      endcase
    end
  end
  // architectural register bank
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spFf <= crs_pkg::SP_RST;
      swFf <= crs_pkg::SW_RST;
      mbsFf <= crs_pkg::MBS_RST;
      rbsFf <= crs_pkg::RBS_RST;
      rdataFf <= 8'h00;
    end else if (clkEn) begin
      spFf <= nxt_spFf;
      swFf <= nxt_swFf;
      mbsFf <= nxt_mbsFf;
      rbsFf <= nxt_rbsFf;
      rdataFf <= nxt_rdataFf;
    end
  end
  // ***************************************************
  // outputs
  // ***************************************************
  assign busy = (stateFf != crs_pkg::ST_IDLE);
  assign cmdReady = (stateFf == crs_pkg::ST_IDLE);
  assign regRdata = rdataFf;
  assign memAddr = memAddrFf;
  assign memWdata = memWdataFf;
  assign memWe = memWeFf;
  assign memRe = memReFf;
  assign pcOut = pcOutFf;
  assign pcLoad = pcLoadFf;
  assign skipNext = skipFf;
  assign popHi = popHiFf;
  assign popLo = popLoFf;
  assign popLoad = popLoadFf;
endmodule
